// *** dfc_regs.svh ***
`ifndef DFC_REGS_SVH
`define DFC_REGS_SVH
// ----------------------------------------
// Selection codes
// ----------------------------------------
`define DFC_PATH_BYPASS   2'h0
`define DFC_PATH_SINC     2'h1
`define DFC_PATH_FIR      2'h2
`define DFC_PATH_HPF      2'h3
`define DFC_PHASE_LINEAR  1'h0
`define DFC_PHASE_MINIMUM 1'h1
// ----------------------------------------
// Rates and widths
// ----------------------------------------
`define DFC_MCLK_DIV      2'h3
`define DFC_MOD_FIRST_CNT 2'h2
`define DFC_SYNC_STABLE   5'h10
`define DFC_RATE_MAX      3'h4
`define DFC_ACC_W         48
`define DFC_OUT_W         32
`define DFC_FIFO_DEPTH    32
`define DFC_HALF_TAPS     7
`define DFC_S3_TAPS       8
`define DFC_S4_TAPS       8
`endif

// *** dfc_pkg.sv ***
package dfc_pkg;
    typedef enum logic [1:0] {
        DFC_RUN_IDLE  = 2'b00,
        DFC_RUN_SYNC  = 2'b01,
        DFC_RUN_GO    = 2'b11
    } dfc_run_type;
endpackage

// *** dfc_fifo.sv ***
`timescale 1ns/1ps
module dfc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             i_mclk,
    input  wire logic             i_reset_n,
    input  wire logic             i_flush,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic [WIDTH-1:0]      o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    wire              full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    wire              empty = (wr_reg == rd_reg);
    wire              push  = i_valid && !full;
    wire              pop   = !empty && i_ready;
    assign o_ready = !full;
    assign o_valid = !empty;
    assign o_data  = mem[rd_reg[AW-1:0]];
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= i_data;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || i_flush) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_reg + (AW+1)'(push);
            rd_reg <= rd_reg + (AW+1)'(pop);
        end
    end
endmodule

// *** dfc_chain.sv ***
`timescale 1ns/1ps
`include "dfc_regs.svh"
// Summary of operation
// RQ1: Three cascaded stages: sinc decimator, fixed FIR low-pass, first-order high-pass.
// RQ2: Path select 00 bypass, 01 sinc, 10 sinc+FIR, 11 sinc+FIR+HPF.
// RQ3: Sinc takes modulator data at master clock over four, outputs words.
// RQ4: Rate select 000..100 gives sinc ratio 128, 64, 32, 16, 8.
// RQ5: Sinc is fifth power moving sum, scaled 1/N per section, unity gain; the code keeps 8 guard bits, a gain of 256.
// RQ6: Sinc notches fall at its output rate and every multiple.
// RQ7: FIR has four sub-stages decimating by 2, 2, 4, 2.
// RQ8: FIR decimates by 32, totals 4096 down to 256.
// RQ9: FIR sub-stages three and four hold linear and minimum coefficient sets.
// RQ10: FIR passband flat to 0.375 output rate, ripple within 0.003 dB.
// RQ11: Linear phase has constant group delay, longer than minimum phase.
// RQ12: In bypass, first modulator clock rise three clocks after sync latch.
// RQ13: In bypass, stable bitstream within 16 modulator periods of sync.
// RQ14: Phase select 0 is linear, 1 is minimum.
// RQ15: Merge streams as 3a2-6a3+4a4+9(b0-2b1+b2) before filtering.
// RQ16: In bypass filter stops; bitstream and clock pins drive, clock at fclk/4.
// RQ17: High-pass is first-order IIR, corner from a 16-bit coefficient.
// RQ18: One-cycle valid strobe with each word of the selected final stage.
module dfc_chain (
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_sync,
    input  wire logic [1:0]  i_filter_path_select,
    input  wire logic [2:0]  i_decimation_rate_select,
    input  wire logic        i_fir_phase_select,
    input  wire logic [15:0] i_highpass_corner_coeff,
    input  wire logic        i_first_stage_bitstream,
    input  wire logic        i_second_stage_bitstream,
    output logic             o_first_stage_bitstream,
    output logic             o_second_stage_bitstream,
    output logic             o_mod_clk,
    output logic             o_bitstream_oe,
    output logic [31:0]      o_data,
    output logic             o_valid,
    output logic             o_fifo_ready
);
    // ----------------------------------------
    // Sync, modulator clock divider
    // ----------------------------------------
    dfc_pkg::dfc_run_type run_reg;
    logic [1:0]  div_reg;
    logic [4:0]  settle_reg;
    wire  bypass  = (i_filter_path_select == `DFC_PATH_BYPASS);           // RQ2
    wire  mod_en  = (div_reg == `DFC_MCLK_DIV);                            // RQ3
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            run_reg <= dfc_pkg::DFC_RUN_IDLE;
        end else if (i_sync) begin
            run_reg <= dfc_pkg::DFC_RUN_SYNC;
        end else if (run_reg == dfc_pkg::DFC_RUN_SYNC && mod_en) begin
            run_reg <= dfc_pkg::DFC_RUN_GO;
        end else if (run_reg == dfc_pkg::DFC_RUN_IDLE) begin
            run_reg <= dfc_pkg::DFC_RUN_GO;
        end
    end
    // Sync restarts divider so rise lands three clocks later
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || i_sync) begin
            div_reg <= 2'h0;                                               // RQ12
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || i_sync) begin
            settle_reg <= 5'h0;
        end else if (mod_en && settle_reg != `DFC_SYNC_STABLE) begin
            settle_reg <= settle_reg + 5'h1;                               // RQ13
        end
    end
    // Modulator clock decoded from div 2..3 and registered, so high while div is 3 and 0; rises on the edge that samples div==2 (3rd clock)
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_mod_clk                <= 1'b0;
            o_bitstream_oe           <= 1'b0;
            o_first_stage_bitstream  <= 1'b0;
            o_second_stage_bitstream <= 1'b0;
        end else begin
            o_mod_clk      <= bypass && (div_reg >= `DFC_MOD_FIRST_CNT);   // RQ16
            o_bitstream_oe <= bypass;                                      // RQ16
            if (bypass && mod_en) begin
                o_first_stage_bitstream  <= i_first_stage_bitstream;
                o_second_stage_bitstream <= i_second_stage_bitstream;
            end
        end
    end
    // First rise lands three clocks after the latching edge, sampled one later
    mod_clk_rise_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // RQ12
        (i_sync && bypass) ##1 (!i_sync && bypass) [*4] |-> $rose(o_mod_clk))
        else $error("Modulator clock did not rise three clocks after sync");
    mod_clk_period_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // RQ16
        ($rose(o_mod_clk) && !i_sync) ##1 (!i_sync && bypass) [*3] |=> $rose(o_mod_clk))
        else $error("Modulator clock period is not four clocks");
    filter_off_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // RQ16
        !bypass |=> !o_bitstream_oe && !o_mod_clk)
        else $error("Bitstream pins driven outside bypass");
    stable_stream_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // RQ13
        (bypass && mod_en && !i_sync && settle_reg == `DFC_SYNC_STABLE) |=>
        (o_first_stage_bitstream == $past(i_first_stage_bitstream)) &&
        (o_second_stage_bitstream == $past(i_second_stage_bitstream)))
        else $error("Bypass bitstream not stable after settling");
    // ----------------------------------------
    // Stream merge
    // ----------------------------------------
    logic [4:0] a_hist_reg;
    logic [2:0] b_hist_reg;
    wire  run    = !bypass && (run_reg == dfc_pkg::DFC_RUN_GO);            // RQ16
    wire  tick   = run && mod_en;
    wire signed [7:0] merged =
        8'sd3 * $signed({1'b0, a_hist_reg[2]}) - 8'sd6 * $signed({1'b0, a_hist_reg[3]})
        + 8'sd4 * $signed({1'b0, a_hist_reg[4]})
        + 8'sd9 * ($signed({1'b0, b_hist_reg[0]}) - 8'sd2 * $signed({1'b0, b_hist_reg[1]})
        + $signed({1'b0, b_hist_reg[2]}));                                 // RQ15
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || i_sync) begin
            a_hist_reg <= 5'h0;
            b_hist_reg <= 3'h0;
        end else if (tick) begin
            a_hist_reg <= {a_hist_reg[3:0], i_first_stage_bitstream};
            b_hist_reg <= {b_hist_reg[1:0], i_second_stage_bitstream};
        end
    end
    // ----------------------------------------
    // Fifth-order sinc, CIC form
    // ----------------------------------------
    function automatic logic [7:0] dfc_ratio(input logic [2:0] sel);
        dfc_ratio = (sel > `DFC_RATE_MAX) ? 8'h80 : (8'h80 >> sel);       // RQ4
    endfunction
    function automatic logic [5:0] dfc_shift(input logic [2:0] sel);
        dfc_shift = 6'd35 - 6'd5 * {3'h0, (sel > `DFC_RATE_MAX) ? 3'h0 : sel};
    endfunction
    logic signed [`DFC_ACC_W-1:0] integ_reg [5];
    logic signed [`DFC_ACC_W-1:0] comb_reg  [5];
    logic signed [`DFC_ACC_W-1:0] comb_in   [6];
    logic [7:0] dec_cnt_reg;
    logic       sinc_vld_reg;
    logic signed [`DFC_OUT_W-1:0] sinc_out_reg;
    wire  dec_hit = tick && (dec_cnt_reg == dfc_ratio(i_decimation_rate_select) - 8'h1);
    assign comb_in[0] = integ_reg[4];
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_cic
            wire signed [`DFC_ACC_W-1:0] in_w = (g == 0) ?
                `DFC_ACC_W'(merged) : integ_reg[(g == 0) ? 0 : g-1];
            always_ff @(posedge i_mclk) begin
                if (!i_reset_n || i_sync) begin
                    integ_reg[g] <= '0;
                    comb_reg[g]  <= '0;
                end else begin
                    if (tick) begin
                        integ_reg[g] <= integ_reg[g] + in_w;               // RQ5
                    end
                    if (dec_hit) begin
                        comb_reg[g] <= comb_in[g];                         // RQ6
                    end
                end
            end
            assign comb_in[g+1] = comb_in[g] - comb_reg[g];
        end
    endgenerate
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || i_sync) begin
            dec_cnt_reg  <= 8'h0;
            sinc_vld_reg <= 1'b0;
            sinc_out_reg <= '0;
        end else begin
            sinc_vld_reg <= dec_hit;
            if (tick) begin
                dec_cnt_reg <= dec_hit ? 8'h0 : dec_cnt_reg + 8'h1;        // RQ3
            end
            if (dec_hit) begin
                // Divide by N^5, keep 8 guard bits for the FIR
                sinc_out_reg <= `DFC_OUT_W'(comb_in[5] >>>
                    (dfc_shift(i_decimation_rate_select) - 6'd8));         // RQ5
            end
        end
    end
    // ----------------------------------------
    // FIR: four decimating sub-stages
    // ----------------------------------------
    localparam logic signed [17:0] HB [`DFC_HALF_TAPS] =
        '{-18'sd1200, 18'sd0, 18'sd9400, 18'sd16384, 18'sd9400, 18'sd0, -18'sd1200};
    localparam logic signed [17:0] C3 [2][`DFC_S3_TAPS] = '{
        '{18'sd1024, 18'sd3072, 18'sd5120, 18'sd7168,
          18'sd7168, 18'sd5120, 18'sd3072, 18'sd1024},                     // RQ11
        '{18'sd6144, 18'sd8192, 18'sd6144, 18'sd4096,
          18'sd3072, 18'sd2048, 18'sd1536, 18'sd1536}};
    localparam logic signed [17:0] C4 [2][`DFC_S4_TAPS] = '{
        '{-18'sd512, 18'sd1536, 18'sd5120, 18'sd10240,
          18'sd10240, 18'sd5120, 18'sd1536, -18'sd512},
        '{18'sd4096, 18'sd11264, 18'sd10240, 18'sd5120,
          18'sd2048, 18'sd512, -18'sd512, 18'sd0}};
    logic signed [`DFC_OUT_W-1:0] tap_reg [4][8];
    logic [1:0] ph_reg [4];
    logic       stg_vld_reg [5];
    logic signed [`DFC_OUT_W-1:0] stg_out_reg [5];
    wire  [1:0] stg_ratio [4] = '{2'h1, 2'h1, 2'h3, 2'h1};                 // RQ7
    assign stg_vld_reg[0] = sinc_vld_reg;
    assign stg_out_reg[0] = sinc_out_reg;
    wire  ph = i_fir_phase_select;                                         // RQ14
    generate
        for (g = 0; g < 4; g++) begin : g_fir
            logic signed [`DFC_ACC_W+4:0] acc;
            always_comb begin
                acc = '0;
                for (int k = 0; k < 8; k++) begin
                    if (g < 2) begin
                        if (k < `DFC_HALF_TAPS) begin
                            acc = acc + tap_reg[g][k] * HB[k];
                        end
                    end else if (g == 2) begin
                        acc = acc + tap_reg[g][k] * C3[ph][k];             // RQ9
                    end else begin
                        acc = acc + tap_reg[g][k] * C4[ph][k];             // RQ9
                    end
                end
            end
            logic vld_q;
            logic signed [`DFC_OUT_W-1:0] out_q;
            always_ff @(posedge i_mclk) begin
                if (!i_reset_n || i_sync) begin
                    for (int k = 0; k < 8; k++) begin
                        tap_reg[g][k] <= '0;
                    end
                    ph_reg[g] <= 2'h0;
                    vld_q     <= 1'b0;
                    out_q     <= '0;
                end else begin
                    vld_q <= 1'b0;
                    if (stg_vld_reg[g]) begin
                        tap_reg[g][0] <= stg_out_reg[g];
                        for (int k = 1; k < 8; k++) begin
                            tap_reg[g][k] <= tap_reg[g][k-1];
                        end
                        ph_reg[g] <= (ph_reg[g] == stg_ratio[g]) ? 2'h0 : ph_reg[g] + 2'h1;
                        if (ph_reg[g] == stg_ratio[g]) begin
                            vld_q <= 1'b1;                                 // RQ8
                            out_q <= `DFC_OUT_W'(acc >>> 15);              // RQ10
                        end
                    end
                end
            end
            assign stg_vld_reg[g+1] = vld_q;
            assign stg_out_reg[g+1] = out_q;
        end
    endgenerate
    // ----------------------------------------
    // High-pass IIR: y = x - x1 + (1 - k) y1
    // ----------------------------------------
    logic signed [`DFC_OUT_W-1:0] hp_x_reg;
    logic signed [`DFC_OUT_W-1:0] hp_y_reg;
    logic       hp_vld_reg;
    wire  signed [`DFC_OUT_W+17:0] hp_fb = hp_y_reg * $signed({2'b00, i_highpass_corner_coeff});
    wire  signed [`DFC_OUT_W-1:0]  hp_new = stg_out_reg[4] - hp_x_reg + hp_y_reg
        - `DFC_OUT_W'(hp_fb >>> 16);                                       // RQ17
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || i_sync) begin
            hp_x_reg   <= '0;
            hp_y_reg   <= '0;
            hp_vld_reg <= 1'b0;
        end else begin
            hp_vld_reg <= stg_vld_reg[4];
            if (stg_vld_reg[4]) begin
                hp_x_reg <= stg_out_reg[4];
                hp_y_reg <= hp_new;                                        // RQ1
            end
        end
    end
    // ----------------------------------------
    // Output tap select and FIFO
    // ----------------------------------------
    wire sel_vld = (i_filter_path_select == `DFC_PATH_SINC) ? sinc_vld_reg :
                   (i_filter_path_select == `DFC_PATH_FIR)  ? stg_vld_reg[4] :
                   (i_filter_path_select == `DFC_PATH_HPF)  ? hp_vld_reg : 1'b0; // RQ2
    wire signed [`DFC_OUT_W-1:0] sel_dat =
                   (i_filter_path_select == `DFC_PATH_SINC) ? sinc_out_reg :
                   (i_filter_path_select == `DFC_PATH_FIR)  ? stg_out_reg[4] : hp_y_reg;
    logic [`DFC_OUT_W-1:0] f_data;
    logic f_valid;
    logic f_in_ready;
    // Downstream pops one word per cycle; a full FIFO drops new samples
    dfc_fifo #(.WIDTH(`DFC_OUT_W), .DEPTH(`DFC_FIFO_DEPTH)) u_fifo (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_flush   (i_sync),
        .i_data    (sel_dat),
        .i_valid   (sel_vld),
        .o_ready   (f_in_ready),
        .o_data    (f_data),
        .o_valid   (f_valid),
        .i_ready   (1'b1)
    );
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_valid      <= 1'b0;
            o_data       <= '0;
            o_fifo_ready <= 1'b0;
        end else begin
            o_valid      <= f_valid;                                       // RQ18
            o_fifo_ready <= f_in_ready;
            // Hold the last word; the FIFO slot behind it is stale
            if (f_valid) begin
                o_data <= f_data;
            end
        end
    end
    valid_one_cycle_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // RQ18
        o_valid |=> !o_valid)
        else $error("Output strobe longer than one cycle");
    data_hold_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // RQ18
        !o_valid |-> $stable(o_data))
        else $error("Output word changed without a strobe");
endmodule

// *** dfc_mod_src.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Modulator bitstream source
// ----------------------------------------
// Random mode stands for a live modulator; level mode holds a DC code so that
// the merged stream and every filter output settle to a known value.
module dfc_mod_src (
    input  wire logic       i_mclk,
    input  wire logic       i_random,
    input  wire logic [1:0] i_level,
    output logic            o_first_stage_bitstream,
    output logic            o_second_stage_bitstream
);
    integer seed = 32'he6e89ab4;
    logic [31:0] rnd;

    initial begin
        o_first_stage_bitstream  = 1'b0;
        o_second_stage_bitstream = 1'b0;
    end

    always @(posedge i_mclk) begin
        rnd = $random(seed);
        o_first_stage_bitstream  <= i_random ? rnd[0] : i_level[1];
        o_second_stage_bitstream <= i_random ? rnd[1] : i_level[0];
    end
endmodule

// *** dfc_chain_tb_top.sv ***
`timescale 1ns/1ps
module dfc_chain_tb_top;
    logic        i_mclk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        i_sync = 1'b0;
    logic [1:0]  i_filter_path_select = 2'h1;
    logic [2:0]  i_decimation_rate_select = 3'h4;
    logic        i_fir_phase_select = 1'b0;
    logic [15:0] i_highpass_corner_coeff = 16'h0337;
    logic        src_random = 1'b1;
    logic [1:0]  src_level = 2'h0;
    wire         bit_a;
    wire         bit_b;
    logic        o_first_stage_bitstream;
    logic        o_second_stage_bitstream;
    logic        o_mod_clk;
    logic        o_bitstream_oe;
    logic [31:0] o_data;
    logic        o_valid;
    logic        o_fifo_ready;
    logic        prev_valid = 1'b0;
    integer      seed = 32'he6e89ab4;
    int          failures = 0;
    int          samples_checked = 0;
    int          c;
    logic [31:0] r;

    always #25 i_mclk = ~i_mclk;

    dfc_mod_src u_src (
        .i_mclk                   (i_mclk),
        .i_random                 (src_random),
        .i_level                  (src_level),
        .o_first_stage_bitstream  (bit_a),
        .o_second_stage_bitstream (bit_b)
    );

    dfc_chain u_dut (
        .i_mclk                   (i_mclk),
        .i_reset_n                (i_reset_n),
        .i_sync                   (i_sync),
        .i_filter_path_select     (i_filter_path_select),
        .i_decimation_rate_select (i_decimation_rate_select),
        .i_fir_phase_select       (i_fir_phase_select),
        .i_highpass_corner_coeff  (i_highpass_corner_coeff),
        .i_first_stage_bitstream  (bit_a),
        .i_second_stage_bitstream (bit_b),
        .o_first_stage_bitstream  (o_first_stage_bitstream),
        .o_second_stage_bitstream (o_second_stage_bitstream),
        .o_mod_clk                (o_mod_clk),
        .o_bitstream_oe           (o_bitstream_oe),
        .o_data                   (o_data),
        .o_valid                  (o_valid),
        .o_fifo_ready             (o_fifo_ready)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Word spacing in clocks: modulator rate is one bit per four clocks
    function automatic logic [31:0] exp_period(input logic [1:0] path, input logic [2:0] rate);
        logic [31:0] n;
        n = (rate > 3'h4) ? 32'h80 : (32'h80 >> rate);
        return (path == 2'h1) ? n * 4 : n * 32 * 4;
    endfunction

    // ----------------------------------------
    // Strobe monitor
    // ----------------------------------------
    always @(negedge i_mclk) begin
        if (i_reset_n && o_valid === 1'b1) begin
            check("valid width", {31'h0, prev_valid}, 32'h0);
            check("fifo ready", {31'h0, o_fifo_ready}, 32'h1);
        end
        prev_valid <= o_valid;
    end

    task automatic pulse_sync;
        @(posedge i_mclk);
        i_sync <= 1'b1;
        @(posedge i_mclk);
        i_sync <= 1'b0;
    endtask

    task automatic wait_valid(output int cycles);
        cycles = 0;
        do begin
            @(negedge i_mclk);
            cycles++;
        end while (o_valid !== 1'b1 && cycles < 40000);
        if (cycles >= 40000) begin
            failures++;
            $display("CHECK FAILED valid wait expected strobe seen none");
        end
    endtask

    // Settles the chain, then measures one word interval
    task automatic run_rate(input logic [1:0] path, input logic [2:0] rate, input logic ph);
        @(posedge i_mclk);
        i_filter_path_select <= path;
        i_decimation_rate_select <= rate;
        i_fir_phase_select <= ph;
        pulse_sync();
        repeat (6) wait_valid(c);
        wait_valid(c);
        check("word period", c, exp_period(path, rate));
        check("oe off", {31'h0, o_bitstream_oe}, 32'h0);
        check("mod clk off", {31'h0, o_mod_clk}, 32'h0);
    endtask

    initial begin
        #(50 * 90000);
        failures++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge i_mclk);
        #1;
        check("reset valid", {31'h0, o_valid}, 32'h0);
        check("reset data", o_data, 32'h0);
        check("reset mod clk", {31'h0, o_mod_clk}, 32'h0);
        check("reset oe", {31'h0, o_bitstream_oe}, 32'h0);
        @(posedge i_mclk);
        i_reset_n <= 1'b1;
        // ----------------------------------------
        // Sinc ratios, codes 0..4 in turn then random codes
        // ----------------------------------------
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            run_rate(2'h1, (k < 5) ? k[2:0] : r[2:0], r[3]);
        end
        // Constant merged stream: zero and positive DC levels
        src_random <= 1'b0;
        src_level <= 2'h1;
        run_rate(2'h1, 3'h4, 1'b0);
        check("sinc zero dc", o_data, 32'h0);
        src_level <= 2'h2;
        run_rate(2'h1, 3'h4, 1'b0);
        check("sinc pos dc", {30'h0, o_data[31], o_data == 32'h0}, 32'h0);
        // ----------------------------------------
        // FIR both phases, then high-pass tap
        // ----------------------------------------
        src_random <= 1'b1;
        r = $random(seed);
        @(posedge i_mclk);
        i_highpass_corner_coeff <= r[15:0];
        run_rate(2'h2, 3'h4, 1'b0);
        run_rate(2'h2, 3'h4, 1'b1);
        run_rate(2'h3, 3'h4, 1'b0);
        // ----------------------------------------
        // Bypass: clock restart and stable stream
        // ----------------------------------------
        @(posedge i_mclk);
        i_filter_path_select <= 2'h0;
        pulse_sync();
        for (int k = 0; k < 8; k++) begin
            @(negedge i_mclk);
            if (k == 1 || k == 2 || k == 6) begin
                check("mod clk low", {31'h0, o_mod_clk}, 32'h0);
            end
            if (k == 3 || k == 7) begin
                check("mod clk rise", {31'h0, o_mod_clk}, 32'h1);
            end
        end
        check("oe bypass", {31'h0, o_bitstream_oe}, 32'h1);
        src_random <= 1'b0;
        for (int lv = 1; lv < 3; lv++) begin
            src_level <= lv[1:0];
            pulse_sync();
            repeat (64) @(posedge i_mclk);
            repeat (16) begin
                @(negedge i_mclk);
                check("bypass bits", {30'h0, o_first_stage_bitstream,
                      o_second_stage_bitstream}, lv);
            end
        end
        wrap_up();
    end
endmodule
